// *** rilc_line_control.sv ***
// Per-line direction and drive control with a classic Wishbone register slave
// How it works
// R1: Every general line has its own output enable bit and value bit.
// R2: After reset every general line is undriven, high impedance.
// R3: Power-on configuration port loads any direction and level per line.
// R4: 160 general lines form four connectors of forty lines each.
// R5: Ganged lines share one value bit and switch in the same cycle.
// R6: Lines 0 to 27 suit fast signals; 28 to 39 slow ones only.
// R7: Eight shared trigger lines can each send and receive.
// R8: Cabled variant maps seven triggers plus oscillator onto the eight positions. Here position 7 is driven from its control bit like the others.
// R9: Each shared trigger line has its own direction bit.
// R10: One driver per shared trigger line; others keep it as input.
// R11: Star trigger line sends to or receives from slot 2 module.
// R12: Right neighbour lines wire straight to the next slot's left lines.
// R13: Left and right neighbour buses are 13 lines, used as general lines.
// R14: Each neighbour line has a direction; adjacent slot line must be input.
// R15: In first slot, left lines fan independent triggers to slots 3 to 15. Here left lines are driven from their control register in every slot.
// R16: Star trigger never driven by this device and another party together.
// R17: All enables and values are registered and reset to input.
//
// Chosen here: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
module rilc_line_control
	import rilc_pkg::*;
#(
	parameter int GIO_N = GIO_LINES,
	parameter int TRIG_N = TRIG_LINES,
	parameter int NBR_N = NBR_LINES
) (
	// Clock and reset
	input wire logic MCLK,
	input wire logic RESET,
	// Classic Wishbone slave
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	// Power-on user configuration load
	input wire logic CFG_LOAD,
	input wire rilc_gio_type CFG_GIO,
	// Slot strap, level, first peripheral slot
	input wire logic FIRST_SLOT,
	// General lines
	input wire logic [GIO_N-1:0] GIO_IN,
	output logic [GIO_N-1:0] GIO_OUT,
	output logic [GIO_N-1:0] GIO_OE_N,
	// Shared chassis triggers
	input wire logic [TRIG_N-1:0] TRIG_IN,
	output logic [TRIG_N-1:0] TRIG_OUT,
	output logic [TRIG_N-1:0] TRIG_OE_N,
	// Star trigger
	input wire logic STAR_IN,
	output logic STAR_OUT,
	output logic STAR_OE_N,
	// Neighbour buses
	input wire logic [NBR_N-1:0] LEFT_IN,
	output logic [NBR_N-1:0] LEFT_OUT,
	output logic [NBR_N-1:0] LEFT_OE_N,
	input wire logic [NBR_N-1:0] RIGHT_IN,
	output logic [NBR_N-1:0] RIGHT_OUT,
	output logic [NBR_N-1:0] RIGHT_OE_N
);
	localparam int GW = GIO_WORDS * 32;

	logic [GW-1:0] gio_out_reg;
	logic [GW-1:0] gio_oe_reg;
	logic [GW-1:0] gang_mask_reg;
	logic [GW-1:0] gio_in_reg;
	logic [31:0] trig_ctrl_reg;
	logic [31:0] left_ctrl_reg;
	logic [31:0] right_ctrl_reg;
	logic [TRIG_N-1:0] trig_in_reg;
	logic [NBR_N-1:0] left_in_reg;
	logic [NBR_N-1:0] right_in_reg;
	logic star_in_reg;
	logic cfg_done_reg;
	logic first_slot_reg;
	logic ack_reg;
	logic [31:0] dat_reg;
	logic gang_val_reg;

	// Byte lane merge used by every writable register
	function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
			input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// Bus request decode
	wire req = WB_CYC_I && WB_STB_I && !ack_reg;
	wire wr = req && WB_WE_I;
	wire [7:0] adr = {WB_ADR_I[7:2], 2'b00};
	wire [7:0] word_rel_out = adr - OFS_GIO_OUT0;
	wire [7:0] word_rel_oe = adr - OFS_GIO_OE0;
	wire [7:0] word_rel_in = adr - OFS_GIO_IN0;
	wire [7:0] word_rel_gang = adr - OFS_GANG_MASK;
	wire hit_out = adr >= OFS_GIO_OUT0 && word_rel_out < 8'(GIO_WORDS * 4);
	wire hit_oe = adr >= OFS_GIO_OE0 && word_rel_oe < 8'(GIO_WORDS * 4);
	wire hit_in = adr >= OFS_GIO_IN0 && word_rel_in < 8'(GIO_WORDS * 4);
	wire hit_gang = adr >= OFS_GANG_MASK && word_rel_gang < 8'(GIO_WORDS * 4);
	wire [2:0] idx_out = word_rel_out[4:2];
	wire [2:0] idx_oe = word_rel_oe[4:2];
	wire [2:0] idx_in = word_rel_in[4:2];
	wire [2:0] idx_gang = word_rel_gang[4:2];

	// Read data selection
	wire [31:0] status_word = {29'h0, first_slot_reg, cfg_done_reg, star_in_reg};
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = UNMAPPED_READ;
		if (hit_out) begin
			rd_mux = gio_out_reg[idx_out*32 +: 32];
		end else if (hit_oe) begin
			rd_mux = gio_oe_reg[idx_oe*32 +: 32];
		end else if (hit_in) begin
			rd_mux = gio_in_reg[idx_in*32 +: 32];
		end else if (hit_gang) begin
			rd_mux = gang_mask_reg[idx_gang*32 +: 32];
		end else if (adr == OFS_TRIG_CTRL) begin
			rd_mux = trig_ctrl_reg;
		end else if (adr == OFS_TRIG_IN) begin
			rd_mux = 32'(trig_in_reg);
		end else if (adr == OFS_LEFT_CTRL) begin
			rd_mux = left_ctrl_reg;
		end else if (adr == OFS_RIGHT_CTRL) begin
			rd_mux = right_ctrl_reg;
		end else if (adr == OFS_NBR_IN) begin
			rd_mux = {3'h0, right_in_reg, 3'h0, left_in_reg};
		end else if (adr == OFS_STATUS) begin
			rd_mux = status_word;
		end
	end

	// Ganged lines take the value of their lowest masked line, one shared bit
	logic [GW-1:0] gang_lowest;
	always_comb begin
		gang_lowest = '0;
		for (int i = GW - 1; i >= 0; i--) begin
			if (gang_mask_reg[i]) begin
				gang_lowest = '0;
				gang_lowest[i] = 1'b1;
			end
		end
	end
	wire gang_val_next = |(gio_out_reg & gang_lowest);

	// Bus acknowledge, one cycle after the request, dropped the cycle after
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			ack_reg <= 1'b0;
			dat_reg <= RST_ZERO;
		end else begin
			ack_reg <= req;
			dat_reg <= rd_mux;
		end
	end
	assign WB_ACK_O = ack_reg;
	assign WB_DAT_O = dat_reg;

	// General line output and enable words, per line independent
	genvar w;
	generate
		for (w = 0; w < GIO_WORDS; w++) begin : g_word
			always_ff @(posedge MCLK or posedge RESET) begin
				if (RESET) begin
					gio_out_reg[w*32 +: 32] <= RST_ZERO; // R2 R17
					gio_oe_reg[w*32 +: 32] <= RST_ZERO; // R2 R17
					gang_mask_reg[w*32 +: 32] <= RST_ZERO;
				end else if (CFG_LOAD && w * 32 < GIO_N) begin
					gio_out_reg[w*32 +: 32] <= 32'(CFG_GIO.val >> (w * 32)); // R3
					gio_oe_reg[w*32 +: 32] <= 32'(~CFG_GIO.oe_n >> (w * 32)); // R3
				end else if (wr) begin
					if (hit_out && idx_out == 3'(w)) begin
						gio_out_reg[w*32 +: 32] <= lane_merge(gio_out_reg[w*32 +: 32],
							WB_DAT_I, WB_SEL_I); // R1
					end
					if (hit_oe && idx_oe == 3'(w)) begin
						gio_oe_reg[w*32 +: 32] <= lane_merge(gio_oe_reg[w*32 +: 32],
							WB_DAT_I, WB_SEL_I); // R1
					end
					if (hit_gang && idx_gang == 3'(w)) begin
						gang_mask_reg[w*32 +: 32] <= lane_merge(gang_mask_reg[w*32 +: 32],
							WB_DAT_I, WB_SEL_I);
					end
				end
			end
		end
	endgenerate

	// Trigger, star and neighbour control registers
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			trig_ctrl_reg <= RST_ZERO; // R17
			left_ctrl_reg <= RST_ZERO; // R17
			right_ctrl_reg <= RST_ZERO; // R17
		end else if (wr) begin
			if (adr == OFS_TRIG_CTRL) begin
				trig_ctrl_reg <= lane_merge(trig_ctrl_reg, WB_DAT_I, WB_SEL_I); // R9
			end
			if (adr == OFS_LEFT_CTRL) begin
				left_ctrl_reg <= lane_merge(left_ctrl_reg, WB_DAT_I, WB_SEL_I); // R14
			end
			if (adr == OFS_RIGHT_CTRL) begin
				right_ctrl_reg <= lane_merge(right_ctrl_reg, WB_DAT_I, WB_SEL_I); // R14
			end
		end
	end

	// Input sampling, strap capture and configuration status
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			gio_in_reg <= '0;
			trig_in_reg <= '0;
			left_in_reg <= '0;
			right_in_reg <= '0;
			star_in_reg <= 1'b0;
			cfg_done_reg <= 1'b0;
			first_slot_reg <= 1'b0;
			gang_val_reg <= 1'b0;
		end else begin
			gio_in_reg <= GW'(GIO_IN);
			trig_in_reg <= TRIG_IN; // R7
			left_in_reg <= LEFT_IN; // R13
			right_in_reg <= RIGHT_IN; // R12
			star_in_reg <= STAR_IN; // R11
			cfg_done_reg <= cfg_done_reg | CFG_LOAD;
			first_slot_reg <= FIRST_SLOT; // R15
			gang_val_reg <= gang_val_next; // R5
		end
	end

	// Pin drive: enable low while driving; ganged lines share one bit
	wire [GW-1:0] gio_val_eff = (gio_out_reg & ~gang_mask_reg) | ({GW{gang_val_reg}}
		& gang_mask_reg); // R5
	assign GIO_OUT = gio_val_eff[GIO_N-1:0]; // R4 R6
	assign GIO_OE_N = ~gio_oe_reg[GIO_N-1:0]; // R1 R2

	// Shared triggers, each with its own enable; position 7 is driven from its control bit like the others
	assign TRIG_OUT = trig_ctrl_reg[TRIG_OUT_LSB +: TRIG_N]; // R7 R8
	assign TRIG_OE_N = ~trig_ctrl_reg[TRIG_OE_LSB +: TRIG_N]; // R9 R10

	// Star line drives only when its enable is set
	assign STAR_OUT = trig_ctrl_reg[STAR_OUT_BIT]; // R11
	assign STAR_OE_N = ~trig_ctrl_reg[STAR_OE_BIT]; // R16

	// Neighbour lines; left lines driven from their control register in every slot, first slot strap not used here
	assign LEFT_OUT = left_ctrl_reg[NBR_OUT_LSB +: NBR_N]; // R13 R15
	assign LEFT_OE_N = ~left_ctrl_reg[NBR_OE_LSB +: NBR_N]; // R14
	assign RIGHT_OUT = right_ctrl_reg[NBR_OUT_LSB +: NBR_N]; // R12
	assign RIGHT_OE_N = ~right_ctrl_reg[NBR_OE_LSB +: NBR_N]; // R14
endmodule

// *** rilc_pkg.sv ***
// Package with constants, register map and line group types for the I/O line controller
package rilc_pkg;
	// Line counts
	localparam int GIO_CONNECTORS = 4;
	localparam int GIO_PER_CONN = 40;
	localparam int GIO_LINES = 160;
	localparam int GIO_FAST_LAST = 27;
	localparam int TRIG_LINES = 8;
	localparam int NBR_LINES = 13;
	localparam int STAR_SLOT = 2;
	localparam int FAN_FIRST_SLOT = 3;
	localparam int FAN_LAST_SLOT = 15;

	// Register byte offsets
	localparam logic [7:0] OFS_GIO_OUT0 = 8'h00;
	localparam logic [7:0] OFS_GIO_OE0 = 8'h18;
	localparam logic [7:0] OFS_GIO_IN0 = 8'h30;
	localparam logic [7:0] OFS_TRIG_CTRL = 8'h48;
	localparam logic [7:0] OFS_TRIG_IN = 8'h4c;
	localparam logic [7:0] OFS_LEFT_CTRL = 8'h50;
	localparam logic [7:0] OFS_RIGHT_CTRL = 8'h54;
	localparam logic [7:0] OFS_NBR_IN = 8'h58;
	localparam logic [7:0] OFS_STATUS = 8'h5c;
	localparam logic [7:0] OFS_GANG_MASK = 8'h60;
	localparam int GIO_WORDS = 5;

	// Field positions
	localparam int TRIG_OUT_LSB = 0;
	localparam int TRIG_OE_LSB = 8;
	localparam int STAR_OUT_BIT = 16;
	localparam int STAR_OE_BIT = 17;
	localparam int NBR_OUT_LSB = 0;
	localparam int NBR_OE_LSB = 16;
	localparam int ST_STAR_IN_BIT = 0;
	localparam int ST_CFG_DONE_BIT = 1;
	localparam int ST_FIRST_SLOT_BIT = 2;

	// Reset values
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;
	localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

	// Bundled pin signals of one line group
	typedef struct packed {
		logic [GIO_LINES-1:0] val;
		logic [GIO_LINES-1:0] oe_n;
	} rilc_gio_type;

	typedef struct packed {
		logic [NBR_LINES-1:0] val;
		logic [NBR_LINES-1:0] oe_n;
	} rilc_nbr_type;
endpackage

// *** rilc_line_control_chk.sv ***
// Checker of bus handshake and line enable timing of the I/O line controller
`timescale 1ns/1ps
module rilc_line_control_chk import rilc_pkg::*; #(
	parameter int GIO_N = GIO_LINES,
	parameter int TRIG_N = TRIG_LINES
) (
	// Clock, reset and bus
	input wire logic MCLK,
	input wire logic RESET,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [31:0] WB_DAT_O,
	input wire logic WB_ACK_O,
	// Configuration and enables
	input wire logic CFG_LOAD,
	input wire rilc_gio_type CFG_GIO,
	input wire logic [GIO_N-1:0] GIO_OE_N,
	input wire logic [TRIG_N-1:0] TRIG_OE_N
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (RESET);
	// Request taken, and bus idle
	wire take = WB_CYC_I && WB_STB_I && !WB_ACK_O;
	wire idle = !(WB_CYC_I && WB_STB_I);
	// Read of an unmapped place, then its answer
	sequence s_rd_unmapped;
		take && !WB_WE_I && WB_ADR_I == 8'h80 ##1 WB_ACK_O;
	endsequence
	a_ack_next: assert property (take |=> WB_ACK_O)
		else $error("ack late");
	a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack too long");
	a_ack_idle: assert property (idle |=> !WB_ACK_O)
		else $error("ack without request");
	a_rd_unmapped: assert property (s_rd_unmapped |-> WB_DAT_O == UNMAPPED_READ)
		else $error("unmapped read not zero");
	a_cfg_oe: assert property (CFG_LOAD |=> GIO_OE_N == $past(CFG_GIO.oe_n))
		else $error("load did not set enables");
	a_gio_hold: assert property (idle && !CFG_LOAD |=> $stable(GIO_OE_N))
		else $error("enable moved without cause");
	a_trig_hold: assert property (idle |=> $stable(TRIG_OE_N))
		else $error("trigger enable moved");
	a_reset_hiz: assert property ($fell(RESET) |-> &GIO_OE_N && &TRIG_OE_N)
		else $error("line driven after reset");
endmodule
bind rilc_line_control rilc_line_control_chk #(.GIO_N(GIO_N), .TRIG_N(TRIG_N)) chk_i (
	.MCLK(MCLK), .RESET(RESET), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
	.WB_ADR_I(WB_ADR_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .CFG_LOAD(CFG_LOAD),
	.CFG_GIO(CFG_GIO), .GIO_OE_N(GIO_OE_N), .TRIG_OE_N(TRIG_OE_N));

// *** rilc_far_model.sv ***
// Far side model: external circuits, trigger bus parties and neighbour slots
`timescale 1ns/1ps
module rilc_far_model import rilc_pkg::*; (
	// Level the far parties drive where the device is an input
	input wire logic far_bit,
	// General lines and neighbour buses
	input wire rilc_gio_type gio,
	output logic [GIO_LINES-1:0] gio_in,
	input wire rilc_nbr_type left_pin,
	output logic [NBR_LINES-1:0] left_in,
	input wire rilc_nbr_type right_pin,
	output logic [NBR_LINES-1:0] right_in,
	// Star trigger on top of the shared triggers
	input wire logic [TRIG_LINES:0] trig_oe_n,
	input wire logic [TRIG_LINES:0] trig_val,
	output logic [TRIG_LINES:0] trig_in
);
	// Far parties stay inputs wherever the device drives
	assign gio_in = (gio.val & ~gio.oe_n) | ({GIO_LINES{far_bit}} & gio.oe_n);
	assign left_in = (left_pin.val & ~left_pin.oe_n)
		| ({NBR_LINES{far_bit}} & left_pin.oe_n);
	assign right_in = (right_pin.val & ~right_pin.oe_n)
		| ({NBR_LINES{far_bit}} & right_pin.oe_n);
	assign trig_in = (trig_val & ~trig_oe_n) | ({TRIG_LINES+1{far_bit}} & trig_oe_n);
endmodule

// *** rilc_line_control_tb_top.sv ***
// Testbench of the I/O line controller: bus sequences with expected line states
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin miscompares++; \
	$display("[FAIL] %0t mismatch %h", $time, a); end end
module rilc_line_control_tb_top import rilc_pkg::*; ();
	logic mclk, reset, cyc, stb, we, cfg_load, first_slot, far_bit, ack;
	logic star_in, star_out, star_oe_n;
	logic [7:0] adr, trig_in, trig_out, trig_oe_n;
	logic [3:0] sel;
	logic [31:0] dat_i, dat_o, rd;
	logic [GIO_LINES-1:0] gio_in, gio_out, gio_oe_n, eo;
	logic [NBR_LINES-1:0] left_in, left_out, left_oe_n, right_in, right_out, right_oe_n;
	rilc_gio_type cfg_gio;
	int miscompares, num_checks;
	// Device and far side
	rilc_line_control rilc_line_control_i (.MCLK(mclk), .RESET(reset), .WB_CYC_I(cyc),
		.WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_i),
		.WB_DAT_O(dat_o), .WB_ACK_O(ack), .CFG_LOAD(cfg_load), .CFG_GIO(cfg_gio),
		.FIRST_SLOT(first_slot), .GIO_IN(gio_in), .GIO_OUT(gio_out), .GIO_OE_N(gio_oe_n),
		.TRIG_IN(trig_in), .TRIG_OUT(trig_out), .TRIG_OE_N(trig_oe_n), .STAR_IN(star_in),
		.STAR_OUT(star_out), .STAR_OE_N(star_oe_n), .LEFT_IN(left_in), .LEFT_OUT(left_out),
		.LEFT_OE_N(left_oe_n), .RIGHT_IN(right_in), .RIGHT_OUT(right_out),
		.RIGHT_OE_N(right_oe_n));
	rilc_far_model rilc_far_model_i (.far_bit(far_bit), .gio({gio_out, gio_oe_n}),
		.gio_in(gio_in), .left_pin({left_out, left_oe_n}), .left_in(left_in),
		.right_pin({right_out, right_oe_n}), .right_in(right_in),
		.trig_oe_n({star_oe_n, trig_oe_n}), .trig_val({star_out, trig_out}),
		.trig_in({star_in, trig_in}));
	// Clock
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// One classic Wishbone cycle; read data lands in rd
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
			input logic [3:0] s = 4'hf);
		int n;
		n = 0;
		@(posedge mclk);
		{cyc, stb, we, adr, sel, dat_i} <= {2'b11, w, a, s, d};
		do begin
			@(posedge mclk);
			n++;
			if (n > 50) begin
				miscompares++;
				$display("[FAIL] %0t ack timeout", $time);
				give_verdict();
			end
		end while (ack !== 1'b1);
		// Ack and read data taken at the edge that samples ack high, then release
		rd = dat_o;
		{cyc, stb} <= 2'b00;
	endtask
	// Reset pulse, then power-on state of the lines
	task automatic reset_chk;
		@(posedge mclk);
		reset <= 1'b1;
		repeat (20) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		`CHK(gio_oe_n, {GIO_LINES{1'b1}})
		`CHK({trig_oe_n, star_oe_n, left_oe_n, right_oe_n}, 35'h7_ffff_ffff)
		wb(1'b0, OFS_STATUS, 32'h0);
		`CHK(rd[2:1], 2'h2)
		$display("test reset done");
	endtask
	// Counts and verdict
	task automatic give_verdict;
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Main sequence
	initial begin
		{cyc, stb, we, cfg_load, far_bit, adr, dat_i, cfg_gio, eo} = '0;
		sel = 4'hf;
		first_slot = 1'b1;
		reset = 1'b1;
		reset_chk();
		for (int w = 0; w < GIO_WORDS; w++) begin
			eo[32*w+:32] = 32'h1 << (7*w);
			wb(1'b1, 8'(OFS_GIO_OE0 + 4*w), eo[32*w+:32]);
			wb(1'b1, 8'(OFS_GIO_OUT0 + 4*w), 32'hffff_ffff);
		end
		`CHK(gio_oe_n, ~eo)
		for (int w = 0; w < GIO_WORDS; w++) begin
			wb(1'b0, 8'(OFS_GIO_IN0 + 4*w), 32'h0);
			`CHK(rd, eo[32*w+:32])
		end
		$display("test general lines done");
		far_bit <= 1'b1;
		wb(1'b1, OFS_TRIG_CTRL, 32'h0002_3ca5);
		`CHK({star_oe_n, star_out, trig_oe_n, trig_out}, 18'h0_c3a5)
		wb(1'b1, OFS_TRIG_IN, 32'h0);
		wb(1'b0, OFS_TRIG_IN, 32'h0);
		`CHK(rd[7:0], 8'he7)
		wb(1'b0, OFS_STATUS, 32'h0);
		`CHK(rd[0], 1'b0)
		// Byte lane 0 only: trigger values clear, enables and star bits kept
		wb(1'b1, OFS_TRIG_CTRL, 32'h5a5a_5a00, 4'h1);
		`CHK({star_oe_n, star_out, trig_oe_n, trig_out}, 18'h0_c300)
		// Star released: far party level comes back in
		wb(1'b1, OFS_TRIG_CTRL, 32'h0000_3c00);
		wb(1'b0, OFS_STATUS, 32'h0);
		`CHK(rd[0], 1'b1)
		wb(1'b1, 8'h80, 32'hffff_ffff);
		wb(1'b0, 8'h80, 32'h0);
		`CHK(rd, UNMAPPED_READ)
		$display("test triggers done");
		wb(1'b1, OFS_LEFT_CTRL, 32'h1001_0aaa);
		wb(1'b1, OFS_RIGHT_CTRL, 32'h0ffe_1555);
		`CHK(left_oe_n, 13'h0ffe)
		`CHK(right_oe_n, 13'h1001)
		`CHK({left_out, right_out}, {13'h0aaa, 13'h1555})
		wb(1'b0, OFS_NBR_IN, 32'h0);
		`CHK(rd, 32'h1555_0ffe)
		$display("test neighbours done");
		cfg_gio <= {{5{32'h1234_5678}}, {5{32'hf0f0_f0f0}}};
		cfg_load <= 1'b1;
		wb(1'b1, OFS_GIO_OE0, 32'hffff_ffff);
		cfg_load <= 1'b0;
		`CHK(gio_oe_n, {5{32'hf0f0_f0f0}})
		`CHK(gio_out, {5{32'h1234_5678}})
		wb(1'b0, OFS_STATUS, 32'h0);
		`CHK(rd[1], 1'b1)
		wb(1'b1, OFS_GANG_MASK, 32'h0000_0003);
		wb(1'b1, OFS_GIO_OUT0, 32'h0000_0001);
		@(negedge mclk);
		`CHK(gio_out[1:0], 2'h3)
		first_slot <= 1'b0;
		wb(1'b0, OFS_STATUS, 32'h0);
		`CHK(rd[2], 1'b0)
		first_slot <= 1'b1;
		$display("test load and gang done");
		reset_chk();
		give_verdict();
	end
endmodule
